// [gpc_pkg.sv]
// Purpose: Constants and types for the port-change I/O port block
// Assumes: 8-bit register file, full address = {bank bit, 7-bit offset}
// Notes: Behaviour list below
// Behaviour
// R01: Eight pins, each input or output.
// R02: Direction one floats pin, zero drives latch.
// R03: Option bit 7 low enables pull-ups on all input pins.
// R04: Output pins never get a pull-up.
// R05: Option register resets to all ones.
// R06: Option bit 6 picks external interrupt edge.
// R07: Only upper four input pins compared.
// R08: OR of mismatches sets port-change flag.
// R09: Port-change interrupt wakes device from sleep.
// R10: Any port read or write reloads latch.
// R11: Mismatch keeps flag set; clear afterwards.
// R12: Software should not poll port during detection.
// R13: Status bits 6:5 select data bank.
// R14: Unimplemented locations read as zero.
// R15: Read returns pins; write updates all latches.
// R16: Interrupt needs enable and global enable set.
package gpc_pkg;

   localparam int PORT_WIDTH = 8;
   localparam int CHG_LSB = 4;
   localparam int CHG_WIDTH = 4;

   ////////////////////////////////////////////////////////////////////
   // Register map, full 8-bit addresses and the 7-bit status offset
   localparam logic [7:0] ADDR_PORT_DATA = 8'h06;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h0B;
   localparam logic [7:0] ADDR_INT_CTRL_MIR = 8'h8B;
   localparam logic [7:0] ADDR_OPTION = 8'h81;
   localparam logic [7:0] ADDR_DIRECTION = 8'h86;
   localparam logic [6:0] OFS_STATUS = 7'h03;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int OPT_PULLUP_DIS_N = 7;
   localparam int OPT_EDGE_SEL = 6;
   localparam int STAT_BANK_HI = 6;
   localparam int STAT_BANK_LO = 5;
   localparam int IC_GLOBAL_EN = 7;
   localparam int IC_TIMER_EN = 5;
   localparam int IC_EXT_EN = 4;
   localparam int IC_CHG_EN = 3;
   localparam int IC_TIMER_FLAG = 2;
   localparam int IC_EXT_FLAG = 1;
   localparam int IC_CHG_FLAG = 0;

   ////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_INT_CTRL = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [1:0] RST_BANK = 2'h0;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] option;
      logic [7:0] interrupt_control;
      logic [1:0] bank;
      logic ext_prev;
      logic [7:0] rdata;
   } gpc_port_state_t;

endpackage

// [gpc_chg_if.sv]
// Purpose: Carrier between port top and change detector
// Assumes: Single clock domain
// Notes: Levels are already synchronised
`timescale 1ns/100ps
interface gpc_chg_if;
   logic [3:0] level;
   logic [3:0] dir_in;
   logic access;
   logic [3:0] mismatch;

   modport port
   (
      output level,
      output dir_in,
      output access,
      input mismatch
   );

   modport detector
   (
      input level,
      input dir_in,
      input access,
      output mismatch
   );
endinterface // gpc_chg_if

// [gpc_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to i_clock
// Notes: Stage one is read only by stage two
`timescale 1ns/100ps
module gpc_sync
   #(parameter int WIDTH = 8)
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } gpc_sync_state_t;

   gpc_sync_state_t state_reg;
   gpc_sync_state_t state_next;

   // Shift chain
   always_comb
   begin
      state_next.s1 = i_async;
      state_next.s2 = state_reg.s1;
   end

   // State register
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign o_sync = state_reg.s2;
endmodule // gpc_sync

// [gpc_change.sv]
// Purpose: Upper-nibble change detector with comparison latch
// Assumes: Access strobe is one cycle per port read or write
// Notes: Output pins are masked from the compare
`timescale 1ns/100ps
module gpc_change
(
   input wire logic i_clock,
   input wire logic i_rst,
   gpc_chg_if.detector chg
);
   typedef struct packed {
      logic [3:0] old;
   } gpc_chg_state_t;

   gpc_chg_state_t state_reg;
   gpc_chg_state_t state_next;

   // Reload comparison value on any port access
   always_comb
   begin
      state_next = state_reg;
      if (chg.access)
      begin
         state_next.old = chg.level; // [R10]
      end
   end

   // State register
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Compare inputs only
   assign chg.mismatch = (chg.level ^ state_reg.old) & chg.dir_in; // [R07]
endmodule // gpc_change

// [gpc_port.sv]
// Purpose: Bidirectional 8-pin port with pull-ups and change interrupt
// Assumes: Core register file strobes, one access per cycle
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/100ps
module gpc_port
   import gpc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [6:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_pullup_en,
   input wire logic i_sleep,
   output logic o_irq,
   output logic o_wake
);
   gpc_port_state_t state_reg;
   gpc_port_state_t state_next;
   logic [7:0] pin_sync;
   logic [7:0] full_addr;
   logic bank_ok;
   logic sel_port;
   logic sel_interrupt_control;
   logic sel_option;
   logic sel_dir;
   logic sel_status;
   logic port_access;
   logic chg_any;
   logic ext_event;
   logic ext_rise;
   logic ext_fall;
   logic [7:0] read_mux;

   gpc_chg_if chg_bus ();

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   gpc_sync #(.WIDTH(PORT_WIDTH)) u_gpc_sync
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_pin),
      .o_sync(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // Change detector hookup
   assign chg_bus.level = pin_sync[CHG_LSB +: CHG_WIDTH];
   assign chg_bus.dir_in = state_reg.dir[CHG_LSB +: CHG_WIDTH]; // [R07]
   assign chg_bus.access = port_access;

   gpc_change u_gpc_change
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .chg(chg_bus.detector)
   );

   assign chg_any = |chg_bus.mismatch; // [R08]

   ////////////////////////////////////////////////////////////////////
   // Address decode with bank select
   always_comb
   begin
      bank_ok = ~state_reg.bank[1]; // [R13]
      full_addr = {state_reg.bank[0], i_addr}; // [R13]
      sel_status = (i_addr == OFS_STATUS);
      sel_port = bank_ok && (full_addr == ADDR_PORT_DATA);
      sel_interrupt_control = bank_ok && (full_addr == ADDR_INT_CTRL ||
                               full_addr == ADDR_INT_CTRL_MIR);
      sel_option = bank_ok && (full_addr == ADDR_OPTION);
      sel_dir = bank_ok && (full_addr == ADDR_DIRECTION);
   end

   assign port_access = sel_port && (i_rd || i_wr); // [R10]

   // External interrupt edge selection
   assign ext_rise = pin_sync[0] && !state_reg.ext_prev;
   assign ext_fall = !pin_sync[0] && state_reg.ext_prev;
   assign ext_event = state_reg.option[OPT_EDGE_SEL] ?
                      ext_rise : ext_fall; // [R06]

   // Read multiplexer, unmapped reads zero
   always_comb
   begin
      read_mux = 8'h00; // [R14]
      if (sel_port)
      begin
         read_mux = pin_sync; // [R15]
      end
      else if (sel_interrupt_control)
      begin
         read_mux = state_reg.interrupt_control;
      end
      else if (sel_option)
      begin
         read_mux = state_reg.option;
      end
      else if (sel_dir)
      begin
         read_mux = state_reg.dir;
      end
      else if (sel_status)
      begin
         read_mux[STAT_BANK_HI] = state_reg.bank[1];
         read_mux[STAT_BANK_LO] = state_reg.bank[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      state_next = state_reg;
      state_next.ext_prev = pin_sync[0];
      if (i_rd)
      begin
         state_next.rdata = read_mux;
      end
      if (i_wr && sel_port)
      begin
         state_next.latch = i_wdata; // [R15]
      end
      if (i_wr && sel_dir)
      begin
         state_next.dir = i_wdata; // [R02]
      end
      if (i_wr && sel_option)
      begin
         state_next.option = i_wdata; // [R03]
      end
      if (i_wr && sel_status)
      begin
         state_next.bank = {i_wdata[STAT_BANK_HI], i_wdata[STAT_BANK_LO]};
      end
      if (i_wr && sel_interrupt_control)
      begin
         state_next.interrupt_control = i_wdata;
      end
      // Hardware set wins over software clear
      if (chg_any)
      begin
         state_next.interrupt_control[IC_CHG_FLAG] = 1'b1; // [R08] [R11]
      end
      if (ext_event)
      begin
         state_next.interrupt_control[IC_EXT_FLAG] = 1'b1; // [R06]
      end
   end

   // State register
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state_reg.latch <= RST_LATCH;
         state_reg.dir <= RST_DIRECTION;
         state_reg.option <= RST_OPTION; // [R05]
         state_reg.interrupt_control <= RST_INT_CTRL;
         state_reg.bank <= RST_BANK;
         state_reg.ext_prev <= 1'b0;
         state_reg.rdata <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drivers and pull-ups, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < PORT_WIDTH; gi++)
      begin : g_pin
         assign o_pin_out[gi] = state_reg.latch[gi]; // [R01]
         assign o_pin_oe[gi] = ~state_reg.dir[gi]; // [R02]
         assign o_pullup_en[gi] = ~state_reg.option[OPT_PULLUP_DIS_N] &
                                  state_reg.dir[gi]; // [R03] [R04]
      end
   endgenerate

   // Interrupt request and wake-up
   assign o_irq = state_reg.interrupt_control[IC_GLOBAL_EN] &&
      ((state_reg.interrupt_control[IC_CHG_EN] && state_reg.interrupt_control[IC_CHG_FLAG]) ||
       (state_reg.interrupt_control[IC_EXT_EN] && state_reg.interrupt_control[IC_EXT_FLAG]) ||
       (state_reg.interrupt_control[IC_TIMER_EN] &&
        state_reg.interrupt_control[IC_TIMER_FLAG])); // [R16]
   assign o_wake = i_sleep && state_reg.interrupt_control[IC_CHG_EN] &&
                   state_reg.interrupt_control[IC_CHG_FLAG]; // [R09]
   assign o_rdata = state_reg.rdata;

   ////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   property p_dir_write;
      logic [7:0] d;
      (i_wr && sel_dir, d = i_wdata) |=> (o_pin_oe == ~d);
   endproperty
   a_dir_write: assert property (p_dir_write) // [R02]
      else $error("Output enable does not follow direction write");

   property p_no_pullup_on_out;
      (o_pullup_en & o_pin_oe) == 8'h00;
   endproperty
   a_no_pullup_on_out: assert property (p_no_pullup_on_out) // [R04]
      else $error("Pull-up active on a driven pin");

   property p_pullup_off;
      (i_wr && sel_option && i_wdata[OPT_PULLUP_DIS_N]) |=>
         (o_pullup_en == 8'h00);
   endproperty
   a_pullup_off: assert property (p_pullup_off) // [R03]
      else $error("Pull-ups still on after disable write");

   // Must run during reset, so the default disable is overridden
   property p_option_reset;
      @(posedge i_clock) disable iff (1'b0)
         i_rst |=> (state_reg.option == RST_OPTION);
   endproperty
   a_option_reset: assert property (p_option_reset) // [R05]
      else $error("Option register not all ones after reset");

   property p_ext_rise;
      (state_reg.option[OPT_EDGE_SEL] && pin_sync[0] &&
       !state_reg.ext_prev) |=> state_reg.interrupt_control[IC_EXT_FLAG];
   endproperty
   a_ext_rise: assert property (p_ext_rise) // [R06]
      else $error("Rising edge did not set external flag");

   property p_ext_fall;
      (!state_reg.option[OPT_EDGE_SEL] && !pin_sync[0] &&
       state_reg.ext_prev) |=> state_reg.interrupt_control[IC_EXT_FLAG];
   endproperty
   a_ext_fall: assert property (p_ext_fall) // [R06]
      else $error("Falling edge did not set external flag");

   property p_mask_outputs;
      (chg_bus.mismatch & ~state_reg.dir[CHG_LSB +: CHG_WIDTH]) == 4'h0;
   endproperty
   a_mask_outputs: assert property (p_mask_outputs) // [R07]
      else $error("Output pin took part in change compare");

   property p_flag_set;
      chg_any |=> state_reg.interrupt_control[IC_CHG_FLAG];
   endproperty
   a_flag_set: assert property (p_flag_set) // [R08]
      else $error("Mismatch did not set change flag");

   property p_access_ends;
      port_access ##1 $stable(pin_sync) |-> !chg_any;
   endproperty
   a_access_ends: assert property (p_access_ends) // [R10]
      else $error("Port access did not end mismatch");

   property p_clear_blocked;
      (i_wr && sel_interrupt_control && !i_wdata[IC_CHG_FLAG] && chg_any) |=>
         state_reg.interrupt_control[IC_CHG_FLAG];
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) // [R11]
      else $error("Flag cleared while mismatch persisted");

   property p_unimpl_zero;
      (i_rd && state_reg.bank[1] && !sel_status) |=> (o_rdata == 8'h00);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) // [R14]
      else $error("Unimplemented location read non-zero");

   property p_port_read;
      (i_rd && sel_port) |=> (o_rdata == $past(pin_sync));
   endproperty
   a_port_read: assert property (p_port_read) // [R15]
      else $error("Port read did not return pin levels");

   property p_irq_gated;
      o_irq |-> state_reg.interrupt_control[IC_GLOBAL_EN];
   endproperty
   a_irq_gated: assert property (p_irq_gated) // [R16]
      else $error("Interrupt raised without global enable");

   property p_irq_change;
      (state_reg.interrupt_control[IC_GLOBAL_EN] && state_reg.interrupt_control[IC_CHG_EN] &&
       state_reg.interrupt_control[IC_CHG_FLAG]) |-> o_irq;
   endproperty
   a_irq_change: assert property (p_irq_change) // [R16]
      else $error("Enabled change flag raised no interrupt");

   property p_wake;
      (i_sleep && chg_any && state_reg.interrupt_control[IC_CHG_EN] &&
       !(i_wr && sel_interrupt_control)) ##1 i_sleep |-> o_wake;
   endproperty
   a_wake: assert property (p_wake) // [R09]
      else $error("Change did not wake from sleep");

   c_flag: cover property (chg_any ##1 state_reg.interrupt_control[IC_CHG_FLAG]);
   c_ext: cover property (ext_event ##1 state_reg.interrupt_control[IC_EXT_FLAG]);
   c_wake: cover property (o_wake);
   c_irq: cover property (o_irq);
endmodule // gpc_port

// [gpc_pins_model.sv]
// Purpose: External keys and wiring on the eight port pins
// Assumes: Bench sets key levels and which keys drive
// Notes: A pin with no driver and no pull-up toggles each cycle on pins 0, 2, 5 and 7, and stays low on 1, 3, 4 and 6
`timescale 1ns/100ps
module gpc_pins_model
(
   input wire logic i_clock,
   input wire logic [7:0] i_out,
   input wire logic [7:0] i_oe,
   input wire logic [7:0] i_pullup_en,
   input wire logic [7:0] i_key_val,
   input wire logic [7:0] i_key_drv,
   output logic [7:0] o_pin
);
   logic [7:0] wander_reg = 8'hA5;

   // Pattern alternating A5 and 00, so floating pins 0, 2, 5 and 7 never look settled
   always_ff @(posedge i_clock)
   begin
      wander_reg <= ~wander_reg ^ 8'h5A;
   end

   // Port driver first, then key, then weak pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (i_oe[i])
            o_pin[i] = i_out[i];
         else if (i_key_drv[i])
            o_pin[i] = i_key_val[i];
         else if (i_pullup_en[i])
            o_pin[i] = 1'b1;
         else
            o_pin[i] = wander_reg[i];
      end
   end
endmodule // gpc_pins_model

// [gpc_port_test.sv]
// Purpose: Self-checking bench for the port-change I/O port
// Assumes: Inputs change at the falling edge
// Notes: Reads are queued and compared by a monitor
`timescale 1ns/100ps
module gpc_port_test;
   import gpc_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic [6:0] i_addr = 7'h00;
   logic i_rd = 1'b0;
   logic i_wr = 1'b0;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] o_rdata, i_pin, o_pin_out, o_pin_oe, o_pullup_en;
   logic i_sleep = 1'b0;
   logic o_irq, o_wake, rd_seen;
   logic [7:0] key_val = 8'h00;
   logic [7:0] key_drv = 8'hFF;
   logic [7:0] v;
   logic [7:0] exp_q[$];
   string name_q[$];
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'hC7C1;

   always #10 i_clock = ~i_clock;

   gpc_port u_gpc_port (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
      .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .o_pullup_en(o_pullup_en), .i_sleep(i_sleep), .o_irq(o_irq),
      .o_wake(o_wake));

   gpc_pins_model u_gpc_pins_model (.i_clock(i_clock), .i_out(o_pin_out),
      .i_oe(o_pin_oe), .i_pullup_en(o_pullup_en), .i_key_val(key_val),
      .i_key_drv(key_drv), .o_pin(i_pin));

   ////////////////////////////////////////////////////////////////////
   // Compare, idle, bus cycles
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clock);
      i_wr = 1'b0;
   endtask

   task automatic rd(input string what, input logic [6:0] a,
      input logic [7:0] e);
      @(negedge i_clock);
      exp_q.push_back(e);
      name_q.push_back(what);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clock);
      i_rd = 1'b0;
   endtask

   task automatic bank(input logic [1:0] b);
      wr(OFS_STATUS, {1'b0, b, 5'h00});
   endtask

   task automatic end_of_test;
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Read data lands one edge after the strobe
   always @(posedge i_clock)
      rd_seen <= i_rd;
   always @(negedge i_clock)
      if (rd_seen === 1'b1 && exp_q.size() > 0)
         check(name_q.pop_front(), o_rdata, exp_q.pop_front());

   // Watchdog
   initial
   begin
      #100000;
      num_errors++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      idle(16);
      i_rst = 1'b0;
      check("oe_rst", o_pin_oe, 8'h00);
      check("pu_rst", o_pullup_en, 8'h00);
      rd("interrupt_control_rst", ADDR_INT_CTRL[6:0], 8'h00);
      rd("unmapped", 7'h07, 8'h00);
      bank(2'h2);
      rd("bank2_port", ADDR_PORT_DATA[6:0], 8'h00);
      rd("status", OFS_STATUS, 8'h40);
      bank(2'h1);
      rd("opt_rst", ADDR_OPTION[6:0], 8'hFF);
      rd("dir_rst", ADDR_DIRECTION[6:0], 8'hFF);
      wr(ADDR_DIRECTION[6:0], 8'h00);
      wr(ADDR_OPTION[6:0], 8'h7F);
      check("oe_all", o_pin_oe, 8'hFF);
      check("pu_out", o_pullup_en, 8'h00);
      wr(ADDR_DIRECTION[6:0], 8'h0F);
      check("oe_hi", o_pin_oe, 8'hF0);
      check("pu_in", o_pullup_en, 8'h0F);
      wr(ADDR_OPTION[6:0], 8'hFF);
      check("pu_off", o_pullup_en, 8'h00);
      wr(ADDR_DIRECTION[6:0], 8'h00);
      bank(2'h0);
      // Random latch values driven and read back
      repeat (4)
      begin
         v = $random(seed);
         wr(ADDR_PORT_DATA[6:0], v);
         check("latch", o_pin_out, v);
         idle(3);
         rd("port_rb", ADDR_PORT_DATA[6:0], v);
      end
      // Change detection, enables, sleep wake
      bank(2'h1);
      wr(ADDR_DIRECTION[6:0], 8'hF0);
      bank(2'h0);
      idle(4);
      rd("port_a", ADDR_PORT_DATA[6:0], {4'h0, v[3:0]});
      wr(ADDR_INT_CTRL[6:0], 8'h88);
      key_val[5] = 1'b1;
      idle(6);
      rd("chg_set", ADDR_INT_CTRL[6:0], 8'h89);
      check("irq", {7'h00, o_irq}, 8'h01);
      i_sleep = 1'b1;
      idle(1);
      check("wake", {7'h00, o_wake}, 8'h01);
      i_sleep = 1'b0;
      wr(ADDR_INT_CTRL[6:0], 8'h88);
      idle(2);
      rd("chg_held", ADDR_INT_CTRL[6:0], 8'h89);
      rd("port_b", ADDR_PORT_DATA[6:0], {4'h2, v[3:0]});
      wr(ADDR_INT_CTRL[6:0], 8'h08);
      idle(2);
      rd("chg_clr", ADDR_INT_CTRL[6:0], 8'h08);
      key_val[4] = 1'b1;
      idle(6);
      rd("chg_noge", ADDR_INT_CTRL[6:0], 8'h09);
      check("irq_noge", {7'h00, o_irq}, 8'h00);
      // Output pins left out of the compare
      key_val = 8'h00;
      wr(ADDR_PORT_DATA[6:0], 8'h10);
      idle(3);
      rd("port_c", ADDR_PORT_DATA[6:0], 8'h00);
      wr(ADDR_INT_CTRL[6:0], 8'h00);
      bank(2'h1);
      wr(ADDR_DIRECTION[6:0], 8'hE1);
      bank(2'h0);
      idle(6);
      rd("masked", ADDR_INT_CTRL[6:0], 8'h00);
      // External pin edge select, rising then falling
      for (int k = 0; k < 2; k++)
      begin
         bank(2'h1);
         wr(ADDR_OPTION[6:0], k ? 8'hBF : 8'hFF);
         bank(2'h0);
         wr(ADDR_INT_CTRL[6:0], 8'h00);
         key_val[0] = 1'b1;
         idle(6);
         rd("ext_up", ADDR_INT_CTRL[6:0], k ? 8'h00 : 8'h02);
         wr(ADDR_INT_CTRL[6:0], 8'h00);
         key_val[0] = 1'b0;
         idle(6);
         rd("ext_dn", ADDR_INT_CTRL[6:0], k ? 8'h02 : 8'h00);
      end
      idle(3);
      end_of_test();
   end
endmodule // gpc_port_test
